// >>> core/ubt_pkg.sv
// Purpose: Shared constants for the bulk-in frame encapsulator
// Assumes: One 50 MHz clock, 32-bit register port
// Notes: Offsets are byte addresses on a 4-bit register port
package ubt_pkg;
	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	localparam int DDEPTH = 2048;
	localparam int CDEPTH = 32;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_HOLD = 4'h4;
	localparam logic [3:0] ADDR_CAP = 4'h8;
	localparam logic [3:0] ADDR_STAT = 4'hc;
	localparam int CFG_MULTI = 0;
	localparam int CFG_REPLY = 1;
	localparam int CFG_LIMIT = 2;
	localparam int CFG_MAXB = 8;
	localparam logic RST_MULTI = 1'h1;
	localparam logic RST_REPLY = 1'h0;
	localparam logic RST_LIMIT = 1'h0;
	localparam logic [3:0] RST_MAXB = 4'h1;
	localparam logic [15:0] HOLD_DLY_US = 16'h0022;
	localparam logic [7:0] RST_CAP = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int US_NS = 1000;
	localparam int US_CYC = US_NS / CLK_PERIOD_NS;
	localparam logic [5:0] US_CYC_M1 = 6'(US_CYC - 1);
	// ----------------------------------------------------------------
	// Link speeds, packet sizes, frame header
	// ----------------------------------------------------------------
	localparam logic [1:0] SPD_FS = 2'h0;
	localparam logic [1:0] SPD_HS = 2'h1;
	localparam logic [1:0] SPD_SS = 2'h2;
	localparam logic [10:0] MPS_FS = 11'h040;
	localparam logic [10:0] MPS_HS = 11'h200;
	localparam logic [10:0] MPS_SS = 11'h400;
	localparam logic [14:0] HDR_BYTES = 15'h000c;
	localparam int LEN_MSB = 13;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b01,
		FR_DATA = 2'b10
	} ubt_fr_e;

	function automatic logic [10:0] ubt_mps_of(input logic [1:0] spd);
		case (spd)
			SPD_SS: ubt_mps_of = MPS_SS;
			SPD_HS: ubt_mps_of = MPS_HS;
			default: ubt_mps_of = MPS_FS;
		endcase
	endfunction

	function automatic logic [12:0] ubt_words_of(input logic [14:0] b);
		ubt_words_of = 13'((b + 15'h0003) >> 2);
	endfunction
endpackage

// >>> core/ubt_bulk_in_transmitter.sv
// Purpose: Packs received frames into bulk-in packets and bursts
// Assumes: Frame FIFO controller and USB core share clk
// Notes: Data store 2K words, command queue 32 packet lengths
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
// Operation
// - Frames start word aligned in multi mode
// - Pad only when another frame follows
// - Header length field never counts pad
// - Packet length includes inter-frame pad
// - Burst ends short or with ZLP
// - Move whole frames when space allows
// - Superspeed burst limited by max-burst field
// - Single mode: no pad, ZLP on multiple
// - Empty token: select set gives ZLP
// - Opposite empty-reply polarity, unconfirmed
// - Hold terminating packet; zero disables
// - Timer expiry sends remaining data
// - Full packet sends early, timer restarts
// - Superspeed waits for full burst
// - Small frame into empty store starts timer
// - Waiting tokens get NAK or NRDY
// - No ACK rewinds; ACK advances controller
// - Keep entries until ACK; ZLP frees no data words
// - Burst limit is count times packet size
// - Limit ends burst or appends frame
// - First frame unchecked; frames never split
// - Command queue of 32 with full
// - Data store 2K words, aligned packets
// - Mode bit; three header words
module ubt_bulk_in_transmitter
	import ubt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Frame FIFO controller side
	input wire logic rx_frame_avail,
	input wire logic rx_valid,
	input wire logic [31:0] rx_word,
	output logic rx_ready,
	output logic fifo_rewind,
	output logic fifo_advance,
	// USB device core side
	input wire logic [1:0] link_speed,
	input wire logic in_token,
	input wire logic tx_word_rd,
	input wire logic host_ack,
	input wire logic host_noack,
	output logic reply_data,
	output logic reply_zlp,
	output logic reply_flow,
	output logic [10:0] pkt_len,
	output logic [5:0] pkt_avail,
	output logic [31:0] tx_word
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic multi_ff, reply_sel_ff, limit_en_ff;
	logic [3:0] maxb_ff;
	logic [15:0] hold_dly_ff;
	logic [7:0] cap_ff;
	logic [31:0] rdata_ff;
	ubt_fr_e fr_ff;
	logic [31:0] data_mem [0:DDEPTH-1];
	logic [10:0] cmd_mem [0:CDEPTH-1];
	logic [11:0] wr_ptr_ff, rd_ptr_ff, ack_ptr_ff;
	logic [5:0] wr_idx_ff, send_idx_ff, head_idx_ff;
	logic [10:0] open_len_ff;
	logic [14:0] rem_ff;
	logic [18:0] burst_cur_ff;
	logic burst_open_ff, single_term_ff, term_q_ff;
	logic [5:0] tick_ff;
	logic [15:0] hold_cnt_ff;
	logic reply_data_ff, reply_zlp_ff, reply_flow_ff;
	logic rewind_ff, advance_ff;
	logic [10:0] pkt_len_ff;
	logic [5:0] pkt_avail_ff;
	logic [31:0] tx_word_ff;
	logic [10:0] mps, pad_len, push_len;
	logic ss, cmd_full, space_ok, pending, hold_hit, quick_term, cap_stop;
	logic idle, term_now, pad_now, pad_full, start_fr, wr_now;
	logic word_full, word_last, push, sendable, idle_empty, tick;
	logic [11:0] used_words, free_words, sum;
	logic [5:0] cmd_cnt, unsent, burst_n;
	logic [14:0] fr_bytes, cur_rem;
	logic [12:0] fr_words;
	logic [18:0] cap_max;
	logic [2:0] wbytes;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			multi_ff <= RST_MULTI;
			reply_sel_ff <= RST_REPLY;
			limit_en_ff <= RST_LIMIT;
			maxb_ff <= RST_MAXB;
			hold_dly_ff <= HOLD_DLY_US;
			cap_ff <= RST_CAP;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_CFG) begin
				multi_ff <= reg_wdata[CFG_MULTI];
				reply_sel_ff <= reg_wdata[CFG_REPLY];
				limit_en_ff <= reg_wdata[CFG_LIMIT];
				maxb_ff <= reg_wdata[CFG_MAXB+3:CFG_MAXB];
			end
			if (reg_addr == ADDR_HOLD) begin
				hold_dly_ff <= reg_wdata[15:0];
			end
			if (reg_addr == ADDR_CAP) begin
				cap_ff <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CFG: rdata_ff <= {20'h00000, maxb_ff, 5'h00,
					limit_en_ff, reply_sel_ff, multi_ff};
				ADDR_HOLD: rdata_ff <= {16'h0000, hold_dly_ff};
				ADDR_CAP: rdata_ff <= {24'h000000, cap_ff};
				ADDR_STAT: rdata_ff <= {4'h0, free_words, 6'h00,
					fr_ff == FR_DATA, pending, 2'h0, cmd_cnt};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Occupancy and limits
	// ----------------------------------------------------------------
	assign mps = ubt_mps_of(link_speed);
	assign ss = link_speed == SPD_SS;
	assign used_words = 12'(wr_ptr_ff - ack_ptr_ff);
	assign free_words = 12'(12'(DDEPTH) - used_words);
	assign cmd_cnt = 6'(wr_idx_ff - head_idx_ff);
	assign unsent = 6'(wr_idx_ff - send_idx_ff);
	assign cmd_full = cmd_cnt == 6'(CDEPTH);
	assign fr_bytes = {1'b0, rx_word[LEN_MSB:0]} + HDR_BYTES;
	assign fr_words = ubt_words_of(fr_bytes);
	assign space_ok = {1'b0, free_words} >= fr_words;
	assign cap_max = {11'h000, cap_ff} * {8'h00, mps};
	assign burst_n = (maxb_ff == 4'h0) ? 6'h01 : {2'h0, maxb_ff};
	assign pending = (open_len_ff != 11'h000) || burst_open_ff;
	assign idle = fr_ff == FR_IDLE;
	assign tick = tick_ff == US_CYC_M1;

	// ----------------------------------------------------------------
	// Frame intake and packet forming
	// ----------------------------------------------------------------
	assign hold_hit = multi_ff && (hold_dly_ff != 16'h0000) && pending
		&& (hold_cnt_ff >= hold_dly_ff);
	assign quick_term = multi_ff && pending && !rx_frame_avail
		&& ((hold_dly_ff == 16'h0000) || limit_en_ff);
	assign cap_stop = limit_en_ff && rx_frame_avail && rx_valid
		&& (burst_cur_ff != 19'h00000)
		&& ({1'b0, burst_cur_ff} + {5'h00, fr_bytes}
		> {1'b0, cap_max});
	assign term_now = idle && !cmd_full && pending && (single_term_ff
		|| hold_hit || quick_term || cap_stop);
	assign pad_len = (open_len_ff + 11'h003) & 11'h7fc;
	assign pad_full = pad_len == mps;
	assign pad_now = idle && !term_now && rx_frame_avail && rx_valid
		&& multi_ff && (open_len_ff[1:0] != 2'h0) && !cmd_full;
	assign start_fr = idle && !term_now && rx_frame_avail && rx_valid
		&& (open_len_ff[1:0] == 2'h0) && space_ok && !cmd_full;
	assign cur_rem = start_fr ? fr_bytes : rem_ff;
	assign wbytes = (cur_rem >= 15'h0004) ? 3'h4 : cur_rem[2:0];
	assign sum = {1'b0, open_len_ff} + {9'h000, wbytes};
	assign wr_now = rx_valid && rx_ready;
	assign word_full = wr_now && (sum == {1'b0, mps});
	assign word_last = wr_now && (cur_rem == {12'h000, wbytes});
	assign push = term_now || word_full || (pad_now && pad_full);
	assign push_len = term_now ? open_len_ff : mps;

	always_comb begin
		unique case (fr_ff)
			FR_IDLE: rx_ready = start_fr;
			FR_DATA: rx_ready = !cmd_full;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fr_ff <= FR_IDLE;
			rem_ff <= 15'h0000;
		end else if (wr_now) begin
			rem_ff <= 15'(cur_rem - {12'h000, wbytes});
			fr_ff <= word_last ? FR_IDLE : FR_DATA;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			open_len_ff <= 11'h000;
			burst_open_ff <= 1'b0;
			burst_cur_ff <= 19'h00000;
			single_term_ff <= 1'b0;
		end else if (term_now) begin
			open_len_ff <= 11'h000;
			burst_open_ff <= 1'b0;
			burst_cur_ff <= 19'h00000;
			single_term_ff <= 1'b0;
		end else if (pad_now) begin
			open_len_ff <= pad_full ? 11'h000 : pad_len;
			burst_open_ff <= burst_open_ff | pad_full;
		end else if (wr_now) begin
			open_len_ff <= word_full ? 11'h000 : sum[10:0];
			burst_open_ff <= burst_open_ff | word_full;
			single_term_ff <= word_last & ~multi_ff;
			if (start_fr) begin
				burst_cur_ff <= 19'(burst_cur_ff
					+ {4'h0, fr_bytes});
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wr_now) begin
			data_mem[wr_ptr_ff[10:0]] <= rx_word;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			cmd_mem[wr_idx_ff[4:0]] <= push_len;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_ff <= 12'h000;
			wr_idx_ff <= 6'h00;
		end else begin
			if (wr_now) begin
				wr_ptr_ff <= 12'(wr_ptr_ff + 12'h001);
			end
			if (push) begin
				wr_idx_ff <= 6'(wr_idx_ff + 6'h01);
			end
		end
	end

	// ----------------------------------------------------------------
	// Hold-delay timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_ff <= 6'h00;
		end else begin
			tick_ff <= tick ? 6'h00 : 6'(tick_ff + 6'h01);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_cnt_ff <= 16'h0000;
		end else if (!pending || word_full || (pad_now && pad_full)
			|| (in_token && sendable)) begin
			hold_cnt_ff <= 16'h0000;
		end else if (tick && (hold_cnt_ff < hold_dly_ff)) begin
			hold_cnt_ff <= 16'(hold_cnt_ff + 16'h0001);
		end
	end

	// ----------------------------------------------------------------
	// Token replies
	// ----------------------------------------------------------------
	assign sendable = (unsent != 6'h00)
		&& (!ss || (unsent >= burst_n) || term_q_ff);
	assign idle_empty = idle && !pending && !rx_frame_avail
		&& (cmd_cnt == 6'h00);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			term_q_ff <= 1'b0;
		end else if (term_now || host_noack) begin
			term_q_ff <= 1'b1;
		end else if (in_token && sendable && (unsent == 6'h01)) begin
			term_q_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reply_data_ff <= 1'b0;
			reply_zlp_ff <= 1'b0;
			reply_flow_ff <= 1'b0;
			pkt_len_ff <= 11'h000;
		end else begin
			reply_data_ff <= in_token && sendable;
			reply_zlp_ff <= in_token && !sendable && idle_empty
				&& reply_sel_ff;
			reply_flow_ff <= in_token && !sendable
				&& !(idle_empty && reply_sel_ff);
			if (in_token && sendable) begin
				pkt_len_ff <= cmd_mem[send_idx_ff[4:0]];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pkt_avail_ff <= 6'h00;
		end else begin
			pkt_avail_ff <= (ss && (unsent > burst_n)) ? burst_n
				: unsent;
		end
	end

	// ----------------------------------------------------------------
	// Transmit, acknowledge and retry
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			send_idx_ff <= 6'h00;
			rd_ptr_ff <= 12'h000;
			tx_word_ff <= 32'h0000_0000;
		end else begin
			if (host_noack) begin
				send_idx_ff <= head_idx_ff;
			end else if (in_token && sendable) begin
				send_idx_ff <= 6'(send_idx_ff + 6'h01);
			end
			if (host_noack) begin
				rd_ptr_ff <= ack_ptr_ff;
			end else if (tx_word_rd) begin
				rd_ptr_ff <= 12'(rd_ptr_ff + 12'h001);
				tx_word_ff <= data_mem[rd_ptr_ff[10:0]];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			head_idx_ff <= 6'h00;
			ack_ptr_ff <= 12'h000;
			rewind_ff <= 1'b0;
			advance_ff <= 1'b0;
		end else begin
			rewind_ff <= host_noack;
			advance_ff <= host_ack && (cmd_cnt != 6'h00);
			if (host_ack && (cmd_cnt != 6'h00)) begin
				head_idx_ff <= 6'(head_idx_ff + 6'h01);
				ack_ptr_ff <= 12'(ack_ptr_ff + ubt_words_of(
					{4'h0, cmd_mem[head_idx_ff[4:0]]}));
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign fifo_rewind = rewind_ff;
	assign fifo_advance = advance_ff;
	assign reply_data = reply_data_ff;
	assign reply_zlp = reply_zlp_ff;
	assign reply_flow = reply_flow_ff;
	assign pkt_len = pkt_len_ff;
	assign pkt_avail = pkt_avail_ff;
	assign tx_word = tx_word_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	pad_align_a:
		assert property (start_fr |-> open_len_ff[1:0] == 2'h0)
		else $error("Frame started off a word boundary");
	single_pad_a:
		assert property (!multi_ff |-> !pad_now)
		else $error("Pad added in single frame mode");
	pad_len_a:
		assert property (pad_now && !pad_full
			|=> open_len_ff[1:0] == 2'h0 && open_len_ff != 11'h000)
		else $error("Pad bytes not counted in packet");
	term_short_a:
		assert property (term_now |-> push && push_len < mps)
		else $error("Burst ended with a full packet");
	full_push_a:
		assert property (word_full |=> wr_idx_ff == 6'($past(wr_idx_ff)
			+ 6'h01) && open_len_ff == 11'h000)
		else $error("Full packet not queued");
	hold_wait_a:
		assert property (term_now && multi_ff && !quick_term && !cap_stop
			|-> hold_cnt_ff >= hold_dly_ff)
		else $error("Short packet released before hold delay");
	ss_burst_a:
		assert property (in_token && ss && unsent < burst_n && !term_q_ff
			&& !(idle_empty && reply_sel_ff)
			|=> !reply_data && reply_flow)
		else $error("Superspeed sent before a full burst");
	empty_zlp_a:
		assert property (in_token && !sendable && idle_empty
			&& reply_sel_ff |=> reply_zlp && !reply_flow)
		else $error("Empty token not answered with ZLP");
	wait_flow_a:
		assert property (in_token && !sendable && !idle_empty
			|=> reply_flow && !reply_data && !reply_zlp)
		else $error("Waiting token not flow controlled");
	rewind_a:
		assert property (host_noack && !host_ack |=> fifo_rewind
			&& send_idx_ff == $past(head_idx_ff)
			&& rd_ptr_ff == $past(ack_ptr_ff))
		else $error("Missing ACK did not rewind");
	ack_pop_a:
		assert property (host_ack && cmd_cnt != 6'h00 |=> fifo_advance
			&& head_idx_ff == 6'($past(head_idx_ff) + 6'h01))
		else $error("ACK did not release the head entry");
	cap_fit_a:
		assert property (start_fr && limit_en_ff && burst_cur_ff != 19'h0
			|-> {1'b0, burst_cur_ff} + {5'h00, fr_bytes}
			<= {1'b0, cap_max})
		else $error("Frame appended beyond burst limit");

	frame_c: cover property (start_fr ##[1:40] word_last);
	zlp_term_c: cover property (term_now && open_len_ff == 11'h000);
	retry_c: cover property (reply_data ##[1:20] host_noack);
	empty_c: cover property (reply_zlp);
endmodule

// >>> testbench/ubt_frame_src.sv
// Purpose: Frame FIFO controller model feeding the bulk-in transmitter
// Assumes: Words change just after clk, held until rx_ready is sampled
// Notes: Bench queues frame lengths with push(); idle lines toggle
`timescale 1ns/100ps
module ubt_frame_src (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Frame intake handshake
	input wire logic rx_ready,
	output logic rx_frame_avail,
	output logic rx_valid,
	output logic [31:0] rx_word
);
	int lens[$];
	int idx;

	// ----------------------------------------------------------------
	// Frame words
	// ----------------------------------------------------------------
	function automatic logic [31:0] word_at(input int len, input int i);
		if (i == 0) begin
			return {18'h0, 14'(len)};
		end
		if (i < 3) begin
			return 32'hc0de0000 | 32'(i);
		end
		return 32'ha5000000 | 32'(len << 8) | 32'(i);
	endfunction

	function automatic void push(input int len);
		lens.push_back(len);
	endfunction

	// ----------------------------------------------------------------
	// Delivery
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx = 0;
			rx_frame_avail <= 1'b0;
			rx_valid <= 1'b0;
			rx_word <= 32'h0;
		end else begin
			if (rx_valid && rx_ready) begin
				idx++;
				if (idx == (lens[0] + 15) / 4) begin
					void'(lens.pop_front());
					idx = 0;
				end
			end
			if (lens.size() > 0) begin
				rx_frame_avail <= 1'b1;
				rx_valid <= 1'b1;
				rx_word <= word_at(lens[0], idx);
			end else begin
				rx_frame_avail <= 1'b0;
				rx_valid <= 1'b0;
				rx_word <= ~rx_word;
			end
		end
	end
endmodule

// >>> testbench/ubt_bulk_in_transmitter_tb.sv
// Purpose: Self-checking bench for the bulk-in transmitter
// Assumes: Hold delay set to 1 us for short runs
// Notes: Bench acts as the USB device core
`timescale 1ns/100ps
module ubt_bulk_in_transmitter_tb;
	import ubt_pkg::*;
	logic clk, rstn, reg_wr, reg_rd, rx_frame_avail, rx_valid, rx_ready;
	logic fifo_rewind, fifo_advance, in_token, tx_word_rd, host_ack;
	logic host_noack, reply_data, reply_zlp, reply_flow;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rx_word, tx_word, rd;
	logic [1:0] link_speed;
	logic [10:0] pkt_len;
	logic [5:0] pkt_avail;
	int error_cnt, tests_run;

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	ubt_bulk_in_transmitter ubt_bulk_in_transmitter_i (.clk(clk),
		.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_frame_avail(rx_frame_avail), .rx_valid(rx_valid),
		.rx_word(rx_word), .rx_ready(rx_ready),
		.fifo_rewind(fifo_rewind), .fifo_advance(fifo_advance),
		.link_speed(link_speed), .in_token(in_token),
		.tx_word_rd(tx_word_rd), .host_ack(host_ack),
		.host_noack(host_noack), .reply_data(reply_data),
		.reply_zlp(reply_zlp), .reply_flow(reply_flow),
		.pkt_len(pkt_len), .pkt_avail(pkt_avail), .tx_word(tx_word));
	ubt_frame_src ubt_frame_src_i (.clk(clk), .rstn(rstn),
		.rx_ready(rx_ready), .rx_frame_avail(rx_frame_avail),
		.rx_valid(rx_valid), .rx_word(rx_word));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic bus_read(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	// 0 word read, 1 ack, 2 no ack, 3 token
	task automatic strobe(input int k);
		@(posedge clk);
		case (k)
			0: tx_word_rd <= 1'b1;
			1: host_ack <= 1'b1;
			2: host_noack <= 1'b1;
			default: in_token <= 1'b1;
		endcase
		@(posedge clk);
		{tx_word_rd, host_ack, host_noack, in_token} <= 4'h0;
		#1;
	endtask

	task automatic set_cfg(input logic multi, input logic limit);
		bus_write(ADDR_CFG, 32'h100 | {29'h0, limit, 1'b0, multi});
		bus_write(ADDR_HOLD, 32'h1);
	endtask

	task automatic take_pkt(input int len, input int wi,
		input logic [31:0] wexp, input bit ack);
		int n;
		logic [2:0] r;
		n = 0;
		r = 3'h0;
		while (r !== 3'b100 && n < 400) begin
			strobe(3);
			r = {reply_data, reply_zlp, reply_flow};
			if (r !== 3'b100) chk({29'h0, r}, 32'h1);
			n++;
		end
		chk({29'h0, r}, 32'h4);
		chk({21'h0, pkt_len}, 32'(len));
		for (int i = 0; i < (len + 3) / 4; i++) begin
			strobe(0);
			if (i == wi) chk(tx_word, wexp);
		end
		strobe(ack ? 1 : 2);
		chk({31'h0, ack ? fifo_advance : fifo_rewind}, 32'h1);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		bus_read(ADDR_CFG);
		chk(rd, 32'h101);
		bus_read(ADDR_HOLD);
		chk(rd, 32'h22);
		bus_read(ADDR_STAT);
		chk(rd, 32'h0800_0000);
		bus_write(ADDR_STAT, 32'hffff_ffff);
		bus_read(ADDR_STAT);
		chk(rd, 32'h0800_0000);
		bus_read(4'h2);
		chk(rd, 32'h0);
	endtask

	task automatic t_empty;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			link_speed <= 2'(s);
			bus_write(ADDR_CFG, 32'h101);
			strobe(3);
			chk({29'h0, reply_data, reply_zlp, reply_flow}, 32'h1);
			bus_write(ADDR_CFG, 32'h103);
			strobe(3);
			chk({29'h0, reply_data, reply_zlp, reply_flow}, 32'h2);
		end
	endtask

	task automatic t_single;
		@(posedge clk);
		link_speed <= SPD_HS;
		set_cfg(1'b0, 1'b0);
		ubt_frame_src_i.push(500);
		take_pkt(512, 0, 32'd500, 1);
		take_pkt(0, -1, 32'h0, 1);
		chk({26'h0, pkt_avail}, 32'h0);
	endtask

	task automatic t_pad_retry;
		set_cfg(1'b1, 1'b0);
		ubt_frame_src_i.push(5);
		ubt_frame_src_i.push(6);
		take_pkt(38, 0, 32'd5, 0);
		take_pkt(38, 5, 32'd6, 1);
		chk({26'h0, pkt_avail}, 32'h0);
	endtask

	task automatic t_full_fs;
		@(posedge clk);
		link_speed <= SPD_FS;
		ubt_frame_src_i.push(116);
		take_pkt(64, 0, 32'd116, 1);
		take_pkt(64, -1, 32'h0, 1);
		take_pkt(0, -1, 32'h0, 1);
	endtask

	task automatic t_limit;
		set_cfg(1'b1, 1'b1);
		bus_write(ADDR_CAP, 32'h1);
		for (int i = 0; i < 3; i++) ubt_frame_src_i.push(20);
		take_pkt(64, 8, 32'd20, 1);
		take_pkt(0, -1, 32'h0, 1);
		take_pkt(32, 0, 32'd20, 1);
		chk({26'h0, pkt_avail}, 32'h0);
	endtask

	task automatic t_ss;
		@(posedge clk);
		link_speed <= SPD_SS;
		bus_write(ADDR_CFG, 32'h201);
		ubt_frame_src_i.push(1012);
		ubt_frame_src_i.push(1012);
		strobe(3);
		chk({29'h0, reply_data, reply_zlp, reply_flow}, 32'h1);
		repeat (700) @(posedge clk);
		chk({26'h0, pkt_avail}, 32'h2);
		take_pkt(1024, 0, 32'd1012, 1);
		take_pkt(1024, 0, 32'd1012, 1);
		take_pkt(0, -1, 32'h0, 1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		error_cnt = 0;
		tests_run = 0;
		rstn = 1'b0;
		{reg_wr, reg_rd, in_token, tx_word_rd, host_ack, host_noack} = 6'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		link_speed = SPD_HS;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_empty();
		t_single();
		t_pad_retry();
		t_full_fs();
		t_limit();
		t_ss();
		stop_test();
	end

	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
